/* pkg/backlight_map.vh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte-wide registers, 250 MHz logic clock
// Notes: Definitions only
`ifndef BACKLIGHT_MAP_VH
`define BACKLIGHT_MAP_VH

// Register offsets
`define ADDR_DIM_LEVEL 8'h00
`define ADDR_DEVICE_CONTROL 8'h01
`define ADDR_FAULT_AND_STATE 8'h02
`define ADDR_CHIP_ID 8'h03

// Reset values
`define DIM_LEVEL_RESET 8'hFF
`define CONTROL_RESET 3'h0
`define FAULT_RESET 8'h00

// Control fields
`define CTL_ENABLE_BIT 0
`define CTL_SOURCE_BIT 1
`define CTL_INTERP_BIT 2

// Fault and state fields
`define FS_SUMMARY_BIT 0
`define FS_THERMAL_BIT 1
`define FS_OVERCURRENT_BIT 2
`define FS_STATE_BIT 3
`define FS_SINGLE_BIT 4
`define FS_DUAL_BIT 5

// Identification fields
`define ID_MARKER 1'h1
`define VENDOR_RESERVED_LO 4'hA
`define VENDOR_RESERVED_HI 4'hE
`define VENDOR_NONE 4'hF

// Timing
`define CLOCK_PERIOD_NS 4
`define ON_DELAY_MAX_NS 4000000
`define ON_DELAY_CYCLES 20'hF4240
`define PWM_TICK_DIV 8'h10
`define CHANNELS 8
`define METER_WIDTH 20

`endif

/* rtl/level_sync.v */
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs asynchronous to clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module level_sync
#(
	parameter WIDTH = 1
)
(
	input wire clock,
	input wire rst_b,
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] level_out
);

reg [WIDTH-1:0] stage1_reg;

always @(posedge clock)
begin
	if (!rst_b)
	begin
		stage1_reg <= {WIDTH{1'b0}};
		level_out <= {WIDTH{1'b0}};
	end
	else
	begin
		stage1_reg <= pin_in;
		level_out <= stage1_reg;
	end
end

endmodule

/* rtl/duty_meter.v */
// Purpose: Measures duty cycle of the external dimming input
// Assumes: Input already synchronised to clock
// Notes: Result is high time * 256 / period, capped at 255
`timescale 1ns/1ns
`include "backlight_map.vh"
module duty_meter
(
	input wire clock,
	input wire rst_b,
	input wire dim_in,
	output reg [7:0] duty
);

localparam W = `METER_WIDTH;

reg prev_reg;
reg running_reg;
reg [W-1:0] period_reg;
reg [W-1:0] high_reg;
reg [W-1:0] divisor_reg;
reg [W:0] rem_reg;
reg [7:0] quot_reg;
reg [3:0] step_reg;
wire rise;
wire [W:0] shifted;

assign rise = dim_in & ~prev_reg;
assign shifted = {rem_reg[W-1:0], 1'b0};

always @(posedge clock)
begin
	if (!rst_b)
	begin
		prev_reg <= 1'b0;
		running_reg <= 1'b0;
		period_reg <= {W{1'b0}};
		high_reg <= {W{1'b0}};
		divisor_reg <= {W{1'b0}};
		rem_reg <= {(W+1){1'b0}};
		quot_reg <= 8'h00;
		step_reg <= 4'h0;
		duty <= 8'h00;
	end
	else
	begin
		prev_reg <= dim_in;
		// Period window between rising edges
		if (rise)
		begin
			period_reg <= {{(W-1){1'b0}}, 1'b1};
			high_reg <= {{(W-1){1'b0}}, 1'b1};
			running_reg <= 1'b1;
			if (running_reg && step_reg == 4'h0)
			begin
				if (high_reg >= period_reg)
					duty <= 8'hFF;
				else
				begin
					divisor_reg <= period_reg;
					rem_reg <= {1'b0, high_reg};
					quot_reg <= 8'h00;
					step_reg <= 4'h8;
				end
			end
		end
		else if (&period_reg)
		begin
			// Static level: full or none
			running_reg <= 1'b0;
			duty <= dim_in ? 8'hFF : 8'h00;
		end
		else
		begin
			period_reg <= period_reg + {{(W-1){1'b0}}, 1'b1};
			if (dim_in)
				high_reg <= high_reg + {{(W-1){1'b0}}, 1'b1};
		end
		// Serial restoring division
		if (step_reg != 4'h0)
		begin
			step_reg <= step_reg - 4'h1;
			if (shifted >= {1'b0, divisor_reg})
			begin
				rem_reg <= shifted - {1'b0, divisor_reg};
				quot_reg <= {quot_reg[6:0], 1'b1};
				if (step_reg == 4'h1)
					duty <= {quot_reg[6:0], 1'b1};
			end
			else
			begin
				rem_reg <= shifted;
				quot_reg <= {quot_reg[6:0], 1'b0};
				if (step_reg == 4'h1)
					duty <= {quot_reg[6:0], 1'b0};
			end
		end
	end
end

endmodule

/* rtl/backlight_fault_status_regs.v */
// Purpose: Control, fault/status and identification registers of a backlight driver
// Assumes: Byte strobes from a serial-bus front end on the same clock
// Notes: Pins pass two flops; outputs come from flops
`timescale 1ns/1ns
`include "backlight_map.vh"
module backlight_fault_status_regs
#(
	parameter [19:0] ON_DELAY_CYCLES = `ON_DELAY_CYCLES,
	parameter [3:0] VENDOR_ID = 4'h3,
	parameter [2:0] SILICON_REV = 3'h0
)
(
	input wire clock,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	input wire thermal_trip,
	input wire input_overcurrent,
	input wire [7:0] channel_off,
	input wire backlight_supply,
	input wire external_dim_input,
	output reg backlight_on,
	output reg [7:0] dim_duty,
	output reg led_pwm,
	output reg summary_fault
);

// Vendor ID is arbitrary; reserved codes fold to the no-code value
function [3:0] vendor_code;
	input [3:0] code;
	begin
		if (code >= `VENDOR_RESERVED_LO && code <= `VENDOR_RESERVED_HI)
			vendor_code = `VENDOR_NONE;
		else
			vendor_code = code;
	end
endfunction

// Number of channels shut down
function [3:0] count_ones;
	input [7:0] bits;
	integer i;
	begin
		count_ones = 4'h0;
		for (i = 0; i < `CHANNELS; i = i + 1)
			count_ones = count_ones + {3'h0, bits[i]};
	end
endfunction

// Register address match
function addr_hit;
	input [7:0] addr;
	input [7:0] offset;
	begin
		addr_hit = (addr == offset);
	end
endfunction

wire [11:0] pins_synced;
wire [7:0] chan_s;
wire thermal_s;
wire overcur_s;
wire supply_s;
wire dim_in_s;
wire [7:0] meter_duty;

// Pin synchronisers
level_sync #(.WIDTH(12)) pin_sync
(
	.clock(clock),
	.rst_b(rst_b),
	.pin_in({external_dim_input, backlight_supply, input_overcurrent,
		thermal_trip, channel_off}),
	.level_out(pins_synced)
);

assign chan_s = pins_synced[7:0];
assign thermal_s = pins_synced[8];
assign overcur_s = pins_synced[9];
assign supply_s = pins_synced[10];
assign dim_in_s = pins_synced[11];

duty_meter meter
(
	.clock(clock),
	.rst_b(rst_b),
	.dim_in(dim_in_s),
	.duty(meter_duty)
);

reg [7:0] dim_level_reg;
reg [2:0] control_reg;
reg [2:0] control_next;
reg summary_reg;
reg summary_next;
reg backlight_state_reg;
reg [19:0] on_count_reg;
reg [7:0] tick_count_reg;
reg [7:0] pwm_count_reg;

wire wr_dim;
wire wr_ctl;
wire wr_fs;
wire host_mode;
wire fault_gate;
wire [3:0] chan_count;
wire thermal_bit;
wire overcur_bit;
wire single_bit;
wire dual_bit;
wire any_fault;
wire enable_toggle;
wire clear_summary;
wire [7:0] status_byte;
wire [7:0] id_byte;
wire [15:0] scaled_product;
wire [7:0] scaled_duty;
wire enable_next;
wire on_done;
wire pwm_tick;
wire pwm_high;
reg [7:0] target_duty;
reg [7:0] read_byte;

assign wr_dim = reg_write & addr_hit(reg_addr, `ADDR_DIM_LEVEL);
assign wr_ctl = reg_write & addr_hit(reg_addr, `ADDR_DEVICE_CONTROL);
assign wr_fs = reg_write & addr_hit(reg_addr, `ADDR_FAULT_AND_STATE);
assign host_mode = ~control_reg[`CTL_SOURCE_BIT];

// Faults count only while lit and supplied
assign fault_gate = backlight_state_reg & supply_s;
assign chan_count = count_ones(chan_s);
assign thermal_bit = fault_gate & thermal_s;
assign overcur_bit = fault_gate & overcur_s;
assign single_bit = fault_gate & (chan_count >= 4'h1);
assign dual_bit = fault_gate & (chan_count >= 4'h2);
assign any_fault = thermal_bit | overcur_bit | single_bit | dual_bit;

// Clear events for the summary flag
assign enable_toggle = wr_ctl & (reg_wdata[`CTL_ENABLE_BIT] != control_reg[`CTL_ENABLE_BIT]);
assign clear_summary = enable_toggle | (wr_fs & ~reg_wdata[`FS_SUMMARY_BIT]);

// Status byte with reserved bits at zero
assign status_byte = {2'b00, dual_bit, single_bit, backlight_state_reg,
	overcur_bit, thermal_bit, summary_reg};

assign id_byte = {`ID_MARKER, vendor_code(VENDOR_ID), SILICON_REV};

// Register level scaled by external duty
assign scaled_product = dim_level_reg * meter_duty + {8'h00, dim_level_reg};
assign scaled_duty = scaled_product[15:8];

// Helpers for sequencing and dimming
assign enable_next = control_next[`CTL_ENABLE_BIT];
assign on_done = (on_count_reg >= ON_DELAY_CYCLES - 20'h00001);
assign pwm_tick = (tick_count_reg == `PWM_TICK_DIV - 8'h01);
assign pwm_high = (pwm_count_reg < dim_duty) || (dim_duty == 8'hFF);

// Control register next value
always @*
begin
	control_next = control_reg;
	if (wr_ctl)
		control_next = reg_wdata[2:0];
end

// Sticky summary flag; a new fault wins over a clear
always @*
begin
	summary_next = summary_reg;
	if (clear_summary)
		summary_next = 1'b0;
	if (any_fault)
		summary_next = 1'b1;
end

// Brightness source selection
always @*
begin
	if (control_reg[`CTL_SOURCE_BIT])
		target_duty = meter_duty;
	else if (control_reg[`CTL_INTERP_BIT])
		target_duty = dim_level_reg;
	else
		target_duty = scaled_duty;
end

// Read multiplexer
always @*
begin
	read_byte = 8'h00;
	if (addr_hit(reg_addr, `ADDR_DIM_LEVEL))
		read_byte = dim_level_reg;
	else if (addr_hit(reg_addr, `ADDR_DEVICE_CONTROL))
		read_byte = {5'h00, control_reg};
	else if (addr_hit(reg_addr, `ADDR_FAULT_AND_STATE))
		read_byte = status_byte;
	else if (addr_hit(reg_addr, `ADDR_CHIP_ID))
		read_byte = id_byte;
end

// Dimming level register
always @(posedge clock)
begin
	if (!rst_b)
		dim_level_reg <= `DIM_LEVEL_RESET;
	else if (wr_dim && host_mode)
		dim_level_reg <= reg_wdata;
end

// Control register
always @(posedge clock)
begin
	if (!rst_b)
		control_reg <= `CONTROL_RESET;
	else
		control_reg <= control_next;
end

// Summary fault flag
always @(posedge clock)
begin
	if (!rst_b)
		summary_reg <= 1'b0;
	else
		summary_reg <= summary_next;
end

// Read port; data holds until the next read
always @(posedge clock)
begin
	if (!rst_b)
	begin
		reg_rdata <= 8'h00;
		reg_rvalid <= 1'b0;
	end
	else
	begin
		reg_rvalid <= reg_read;
		if (reg_read)
			reg_rdata <= read_byte;
	end
end

// Backlight on/off sequencing
always @(posedge clock)
begin
	if (!rst_b)
	begin
		backlight_state_reg <= 1'b0;
		on_count_reg <= 20'h00000;
	end
	else if (!enable_next || !supply_s)
	begin
		backlight_state_reg <= 1'b0;
		on_count_reg <= 20'h00000;
	end
	else if (!backlight_state_reg)
	begin
		if (on_done)
			backlight_state_reg <= 1'b1;
		else
			on_count_reg <= on_count_reg + 20'h00001;
	end
end

// Dimming tick divider
always @(posedge clock)
begin
	if (!rst_b)
		tick_count_reg <= 8'h00;
	else if (pwm_tick)
		tick_count_reg <= 8'h00;
	else
		tick_count_reg <= tick_count_reg + 8'h01;
end

// Dimming output
always @(posedge clock)
begin
	if (!rst_b)
	begin
		pwm_count_reg <= 8'h00;
		dim_duty <= 8'h00;
		led_pwm <= 1'b0;
	end
	else
	begin
		if (pwm_tick)
			pwm_count_reg <= pwm_count_reg + 8'h01;
		dim_duty <= backlight_state_reg ? target_duty : 8'h00;
		led_pwm <= backlight_state_reg & pwm_high;
	end
end

// Backlight state mirror
always @(posedge clock)
begin
	if (!rst_b)
		backlight_on <= 1'b0;
	else
		backlight_on <= backlight_state_reg;
end

// Summary flag mirror
always @(posedge clock)
begin
	if (!rst_b)
		summary_fault <= 1'b0;
	else
		summary_fault <= summary_next;
end

endmodule

/* sim/dim_source.sv */
// Purpose: External dimming waveform source
// Assumes: 80 ns period, 1 ns phase offset
// Notes: Pin stays low while not running
`timescale 1ns/1ns
module dim_source
#(
	parameter HIGH_NS = 20
)
(
	input wire run,
	output logic pwm
);
	initial
	begin
		pwm = 1'b0;
		#1;
		forever
		begin
			if (run)
			begin
				pwm = 1'b1;
				#(HIGH_NS);
				pwm = 1'b0;
				#(80 - HIGH_NS);
			end
			else
				#80;
		end
	end
endmodule

/* sim/backlight_regs_monitor.sv */
// Purpose: Port checker for the backlight register bank
// Assumes: Synchronous active-low reset
// Notes: Bound to the top module
`timescale 1ns/1ns
module backlight_regs_monitor
(
	input wire clock,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire reg_rvalid,
	input wire thermal_trip,
	input wire input_overcurrent,
	input wire [7:0] channel_off,
	input wire backlight_supply,
	input wire backlight_on,
	input wire [7:0] dim_duty,
	input wire led_pwm,
	input wire summary_fault
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence rd_status;
		reg_read && reg_addr == 8'h02;
	endsequence
	sequence quiet;
		!thermal_trip && !input_overcurrent && channel_off == 8'h00;
	endsequence
	sequence off_write;
		reg_write && reg_addr == 8'h01 && !reg_wdata[0];
	endsequence
	a_read_answer: assert property (reg_read |=> reg_rvalid)
		else $error("read not answered");
	a_state_bit: assert property (rd_status |=> reg_rdata[3] == backlight_on)
		else $error("state bit differs");
	a_summary_bit: assert property (rd_status |=> reg_rdata[0] == $past(summary_fault))
		else $error("summary bit differs");
	a_reserved_zero: assert property (rd_status |=> reg_rdata[7:6] == 2'h0)
		else $error("reserved bits set");
	a_flag_sticky: assert property (summary_fault && !reg_write |=> summary_fault)
		else $error("flag lost");
	a_no_spurious: assert property (quiet [*5] ##0 !summary_fault |=> !summary_fault)
		else $error("flag without cause");
	a_supply_loss: assert property (!backlight_supply [*4] ##0 !summary_fault |=> !summary_fault)
		else $error("flag on supply loss");
	a_off_dark: assert property (!backlight_on [*3] |-> dim_duty == 8'h00 && !led_pwm)
		else $error("light while off");
	a_turn_off: assert property (off_write |-> ##[1:2] !backlight_on)
		else $error("late turn off");
	a_id_fields: assert property (reg_read && reg_addr == 8'h03 |=> reg_rdata[7]
		&& (reg_rdata[6:3] < 4'hA || reg_rdata[6:3] == 4'hF))
		else $error("bad id byte");
endmodule
bind backlight_fault_status_regs backlight_regs_monitor i_mon (.clock(clock), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .thermal_trip(thermal_trip),
	.input_overcurrent(input_overcurrent), .channel_off(channel_off),
	.backlight_supply(backlight_supply), .backlight_on(backlight_on), .dim_duty(dim_duty),
	.led_pwm(led_pwm), .summary_fault(summary_fault));

/* sim/backlight_fault_status_regs_test.sv */
// Purpose: Register and fault tests of the backlight bank
// Assumes: On delay shortened to 20 cycles
// Notes: Fault pins driven directly
`timescale 1ns/1ns
module backlight_fault_status_regs_test;
	logic clock, rst_b, reg_write, reg_read, thermal_trip, input_overcurrent;
	logic backlight_supply, dim_run;
	logic [7:0] reg_addr, reg_wdata, channel_off;
	wire [7:0] reg_rdata, dim_duty;
	wire reg_rvalid, backlight_on, led_pwm, summary_fault, ext_dim;
	int err_total, n_checks, cyc;
	backlight_fault_status_regs #(.ON_DELAY_CYCLES(20'h00014)) i_dut (.clock(clock),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.thermal_trip(thermal_trip), .input_overcurrent(input_overcurrent),
		.channel_off(channel_off), .backlight_supply(backlight_supply),
		.external_dim_input(ext_dim), .backlight_on(backlight_on), .dim_duty(dim_duty),
		.led_pwm(led_pwm), .summary_fault(summary_fault));
	dim_source i_src (.run(dim_run), .pwm(ext_dim));
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task pause(input int n);
		repeat (n) @(posedge clock);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
		chk("rdata", reg_rdata, exp);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_total++;
			close_out;
		end
	end
	initial
	begin
		{rst_b, reg_write, reg_read, thermal_trip, input_overcurrent, dim_run} = 6'h00;
		{reg_addr, reg_wdata, channel_off} = 24'h000000;
		backlight_supply = 1'b1;
		{err_total, n_checks, cyc} = 0;
		pause(6);
		rst_b <= 1'b1;
		rd(8'h00, 8'hFF);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h98);
		rd(8'h05, 8'h00);
		$display("test reset done");
		wr(8'h00, 8'h55);
		rd(8'h00, 8'h55);
		wr(8'h00, 8'hAA);
		wr(8'h01, 8'hFA);
		rd(8'h01, 8'h02);
		wr(8'h00, 8'h11);
		rd(8'h00, 8'hAA);
		wr(8'h03, 8'h00);
		rd(8'h03, 8'h98);
		$display("test access done");
		wr(8'h01, 8'h05);
		pause(25);
		rd(8'h02, 8'h08);
		chk("backlight_on", {7'h00, backlight_on}, 8'h01);
		chk("dim_duty", dim_duty, 8'hAA);
		dim_run <= 1'b1;
		wr(8'h01, 8'h03);
		pause(120);
		chk("dim_duty", dim_duty, 8'h40);
		wr(8'h01, 8'h01);
		pause(4);
		chk("dim_duty", dim_duty, 8'h2B);
		dim_run <= 1'b0;
		wr(8'h01, 8'h05);
		$display("test dimming done");
		thermal_trip <= 1'b1;
		pause(6);
		rd(8'h02, 8'h0B);
		chk("summary_fault", {7'h00, summary_fault}, 8'h01);
		thermal_trip <= 1'b0;
		pause(6);
		rd(8'h02, 8'h09);
		wr(8'h02, 8'hFF);
		rd(8'h02, 8'h09);
		wr(8'h02, 8'h00);
		rd(8'h02, 8'h08);
		chk("summary_fault", {7'h00, summary_fault}, 8'h00);
		input_overcurrent <= 1'b1;
		pause(6);
		wr(8'h02, 8'h00);
		rd(8'h02, 8'h0D);
		input_overcurrent <= 1'b0;
		channel_off <= 8'h04;
		pause(6);
		rd(8'h02, 8'h19);
		channel_off <= 8'h24;
		pause(6);
		rd(8'h02, 8'h39);
		channel_off <= 8'h00;
		pause(6);
		rd(8'h02, 8'h09);
		wr(8'h01, 8'h04);
		rd(8'h02, 8'h00);
		$display("test faults done");
		thermal_trip <= 1'b1;
		wr(8'h01, 8'h05);
		wr(8'h01, 8'h04);
		pause(6);
		rd(8'h02, 8'h00);
		backlight_supply <= 1'b0;
		wr(8'h01, 8'h05);
		pause(30);
		rd(8'h02, 8'h00);
		chk("backlight_on", {7'h00, backlight_on}, 8'h00);
		$display("test supply done");
		rst_b <= 1'b0;
		pause(6);
		rst_b <= 1'b1;
		rd(8'h00, 8'hFF);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		$display("test second reset done");
		close_out;
	end
endmodule
